/* pct_pkg.sv */
// Shared types and constants for the opcode timing decoder
package pct_pkg;

  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } pct_state_t;

  // Instruction class reported with each decoded opcode
  typedef enum logic [3:0] {
    K_ARITH   = 4'h0,
    K_LOGIC   = 4'h1,
    K_MOVE    = 4'h2,
    K_XRAM    = 4'h3,
    K_CODE    = 4'h4,
    K_STACK   = 4'h5,
    K_SWAP    = 4'h6,
    K_CALL    = 4'h7,
    K_JUMP    = 4'h8,
    K_BRANCH  = 4'h9,
    K_BIT     = 4'hA,
    K_ILLEGAL = 4'hB
  } pct_kind_t;

  // Which core condition decides a conditional branch
  typedef enum logic [3:0] {
    C_NONE   = 4'h0,
    C_ZERO   = 4'h1,
    C_NZERO  = 4'h2,
    C_CARRY  = 4'h3,
    C_NCARRY = 4'h4,
    C_BSET   = 4'h5,
    C_BCLR   = 4'h6,
    C_UNEQ   = 4'h7,
    C_DNZ    = 4'h8
  } pct_cond_t;

  // Condition levels from the core, same clock domain
  typedef struct packed {
    logic acc_zero;
    logic carry;
    logic bit_set;
    logic unequal;
    logic dec_nonzero;
  } pct_flags_t;

  // One decode table row
  typedef struct packed {
    pct_kind_t kind;
    logic [1:0] len;
    logic [4:0] cyc_nt;
    logic [4:0] cyc_tk;
    pct_cond_t cond;
  } pct_row_t;

  // Result handed back to the core
  typedef struct packed {
    pct_kind_t kind;
    logic [1:0] len;
    logic [4:0] cycles;
    logic taken;
  } pct_result_t;

  localparam logic [4:0] CYC_PRODUCT_8X8 = 5'h0B;
  localparam logic [4:0] CYC_PRODUCT_16X8 = 5'h14;
  localparam logic [4:0] CYC_DIVIDE_8X8 = 5'h0B;
  localparam logic [4:0] CYC_DIVIDE_16X8 = 5'h14;
  localparam logic [4:0] CNT_RESET = 5'h00;
  localparam pct_result_t RESULT_RESET = '{K_ILLEGAL, 2'h0, 5'h00, 1'b0};

endpackage

/* pct_decoder.sv */
// Opcode decoder and cycle sequencer for the pipelined accumulator core
// What this block does
// RULE1: Add with register, direct, immediate and indirect forms at their lengths and times.
// RULE2: Add with carry: register one cycle, direct/immediate two, indirect two.
// RULE3: Subtract with borrow: direct and immediate two bytes two cycles, indirect two.
// RULE4: Subtract with borrow from a working register 0x98-0x9F: one byte, one cycle.
// RULE5: Increment accumulator, register, direct, indirect and data pointer at given times.
// RULE6: Decrement accumulator, register, direct and indirect at given times.
// RULE7: Multiply 0xA4 takes 11 cycles for 8x8 and 20 for 16x8.
// RULE8: Divide at 0x84 in two forms; decimal adjust 0xD4 one byte one cycle.
// RULE9: Logical and into accumulator or direct byte with given times.
// RULE10: Logical or into accumulator or direct byte with given times.
// RULE11: Exclusive or into accumulator or direct byte with given times.
// RULE12: Clear, complement, rotates and no-op one cycle; nibble swap four.
// RULE13: Load accumulator from register, direct, indirect or immediate.
// RULE14: Write working register from accumulator, direct or immediate.
// RULE15: Write direct byte from accumulator, register, direct, indirect or immediate.
// RULE16: Write indirect RAM three ways; load data pointer in three cycles.
// RULE17: Code table read via data pointer 7 cycles, via program counter 8.
// RULE18: External RAM reads 5 or 6 cycles, writes 4 or 5 cycles.
// RULE19: Push 5, pop 4, register exchange 3, other exchanges 4 cycles.
// RULE20: Calls take 7 cycles; both returns take 8.
// RULE21: Absolute and short jumps 4, long jump 5, indirect jump 6 cycles.
// RULE22: Zero, nonzero and register loop branches 3/5; carry branches 2/4.
// RULE23: Bit branches, compare branches and direct loop branch take 4/6.
// RULE24: Carry ops one cycle, bit writes three, bit-to-carry two, carry-to-bit three.
// RULE25: Each figure is one core clock; taken count only when condition holds.
`timescale 1ns/1ps

module pct_decoder (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic op_valid_in,
  input wire logic [7:0] opcode_in,
  input wire logic wide_form_in,
  input wire pct_pkg::pct_flags_t flags_in,
  output logic ready_out,
  output logic busy_out,
  output logic done_out,
  output pct_pkg::pct_result_t result_out
);

  pct_pkg::pct_state_t state_reg;
  pct_pkg::pct_state_t state_next;
  logic [4:0] cnt_reg;
  logic done_reg;
  pct_pkg::pct_result_t result_reg;
  pct_pkg::pct_row_t row;
  pct_pkg::pct_result_t dec;
  logic take;
  logic [4:0] prod_cyc;
  logic [4:0] div_cyc;
  logic accept;

  function automatic pct_pkg::pct_row_t op(input pct_pkg::pct_kind_t k,
      input logic [1:0] l, input logic [4:0] n);
    op = '{k, l, n, n, pct_pkg::C_NONE};
  endfunction

  function automatic pct_pkg::pct_row_t br(input logic [1:0] l,
      input logic [4:0] n, input logic [4:0] t, input pct_pkg::pct_cond_t c);
    br = '{pct_pkg::K_BRANCH, l, n, t, c};
  endfunction

  // Operand form picks the long multiply and divide counts
  assign prod_cyc = wide_form_in ? pct_pkg::CYC_PRODUCT_16X8 : pct_pkg::CYC_PRODUCT_8X8; // see RULE7
  assign div_cyc = wide_form_in ? pct_pkg::CYC_DIVIDE_16X8 : pct_pkg::CYC_DIVIDE_8X8; // see RULE8

  always_comb begin
    // Low nibble 1 is only used by the paged call and jump forms
    casez (opcode_in)
      8'b???10001:
        row = op(pct_pkg::K_CALL, 2'h2, 5'h07); // see RULE20
      8'b???00001:
        row = op(pct_pkg::K_JUMP, 2'h2, 5'h04); // see RULE21
      // Add
      8'b00101???: row = op(pct_pkg::K_ARITH, 2'h1, 5'h01); // see RULE1
      8'h24: row = op(pct_pkg::K_ARITH, 2'h2, 5'h02); // see RULE1
      8'h25: row = op(pct_pkg::K_ARITH, 2'h2, 5'h02); // see RULE1
      8'b0010011?: row = op(pct_pkg::K_ARITH, 2'h1, 5'h02); // see RULE1
      // Add with carry
      8'b00111???: row = op(pct_pkg::K_ARITH, 2'h1, 5'h01); // see RULE2
      8'h34: row = op(pct_pkg::K_ARITH, 2'h2, 5'h02); // see RULE2
      8'h35: row = op(pct_pkg::K_ARITH, 2'h2, 5'h02); // see RULE2
      8'b0011011?: row = op(pct_pkg::K_ARITH, 2'h1, 5'h02); // see RULE2
      // Subtract with borrow; register form matches the other register forms
      8'b10011???: row = op(pct_pkg::K_ARITH, 2'h1, 5'h01); // see RULE4
      8'h94: row = op(pct_pkg::K_ARITH, 2'h2, 5'h02); // see RULE3
      8'h95: row = op(pct_pkg::K_ARITH, 2'h2, 5'h02); // see RULE3
      8'b1001011?: row = op(pct_pkg::K_ARITH, 2'h1, 5'h02); // see RULE3
      // Increment
      8'h04: row = op(pct_pkg::K_ARITH, 2'h1, 5'h01); // see RULE5
      8'b00001???: row = op(pct_pkg::K_ARITH, 2'h1, 5'h02); // see RULE5
      8'h05: row = op(pct_pkg::K_ARITH, 2'h2, 5'h03); // see RULE5
      8'b0000011?: row = op(pct_pkg::K_ARITH, 2'h1, 5'h03); // see RULE5
      8'hA3: row = op(pct_pkg::K_ARITH, 2'h1, 5'h04); // see RULE5
      // Decrement
      8'h14: row = op(pct_pkg::K_ARITH, 2'h1, 5'h01); // see RULE6
      8'b00011???: row = op(pct_pkg::K_ARITH, 2'h1, 5'h02); // see RULE6
      8'h15: row = op(pct_pkg::K_ARITH, 2'h2, 5'h03); // see RULE6
      8'b0001011?: row = op(pct_pkg::K_ARITH, 2'h1, 5'h03); // see RULE6
      // Multiply and divide time follows the operand form
      8'hA4: row = op(pct_pkg::K_ARITH, 2'h1, prod_cyc); // see RULE7
      8'h84: row = op(pct_pkg::K_ARITH, 2'h1, div_cyc); // see RULE8
      // Decimal adjust
      8'hD4: row = op(pct_pkg::K_ARITH, 2'h1, 5'h01); // see RULE8
      // Logical and; high nibble 7 holds moves and bit ops, not logic
      8'b01011???: row = op(pct_pkg::K_LOGIC, 2'h1, 5'h01); // see RULE9
      8'h54: row = op(pct_pkg::K_LOGIC, 2'h2, 5'h02); // see RULE9
      8'h55: row = op(pct_pkg::K_LOGIC, 2'h2, 5'h02); // see RULE9
      8'b0101011?: row = op(pct_pkg::K_LOGIC, 2'h1, 5'h02); // see RULE9
      8'h52: row = op(pct_pkg::K_LOGIC, 2'h2, 5'h03); // see RULE9
      8'h53: row = op(pct_pkg::K_LOGIC, 2'h3, 5'h03); // see RULE9
      // Logical or
      8'b01001???: row = op(pct_pkg::K_LOGIC, 2'h1, 5'h01); // see RULE10
      8'h44: row = op(pct_pkg::K_LOGIC, 2'h2, 5'h02); // see RULE10
      8'h45: row = op(pct_pkg::K_LOGIC, 2'h2, 5'h02); // see RULE10
      8'b0100011?: row = op(pct_pkg::K_LOGIC, 2'h1, 5'h02); // see RULE10
      8'h42: row = op(pct_pkg::K_LOGIC, 2'h2, 5'h03); // see RULE10
      8'h43: row = op(pct_pkg::K_LOGIC, 2'h3, 5'h03); // see RULE10
      // Exclusive or
      8'b01101???: row = op(pct_pkg::K_LOGIC, 2'h1, 5'h01); // see RULE11
      8'h64: row = op(pct_pkg::K_LOGIC, 2'h2, 5'h02); // see RULE11
      8'h65: row = op(pct_pkg::K_LOGIC, 2'h2, 5'h02); // see RULE11
      8'b0110011?: row = op(pct_pkg::K_LOGIC, 2'h1, 5'h02); // see RULE11
      8'h62: row = op(pct_pkg::K_LOGIC, 2'h2, 5'h03); // see RULE11
      8'h63: row = op(pct_pkg::K_LOGIC, 2'h3, 5'h03); // see RULE11
      // Accumulator one-cycle operations and no-op, then the four-cycle nibble swap
      8'hE4: row = op(pct_pkg::K_LOGIC, 2'h1, 5'h01); // see RULE12
      8'hF4: row = op(pct_pkg::K_LOGIC, 2'h1, 5'h01); // see RULE12
      8'h23: row = op(pct_pkg::K_LOGIC, 2'h1, 5'h01); // see RULE12
      8'h33: row = op(pct_pkg::K_LOGIC, 2'h1, 5'h01); // see RULE12
      8'h03: row = op(pct_pkg::K_LOGIC, 2'h1, 5'h01); // see RULE12
      8'h13: row = op(pct_pkg::K_LOGIC, 2'h1, 5'h01); // see RULE12
      8'h00: row = op(pct_pkg::K_LOGIC, 2'h1, 5'h01); // see RULE12
      8'hC4: row = op(pct_pkg::K_LOGIC, 2'h1, 5'h04); // see RULE12
      // Load accumulator
      8'b11101???: row = op(pct_pkg::K_MOVE, 2'h1, 5'h01); // see RULE13
      8'hE5: row = op(pct_pkg::K_MOVE, 2'h2, 5'h02); // see RULE13
      8'h74: row = op(pct_pkg::K_MOVE, 2'h2, 5'h02); // see RULE13
      8'b1110011?: row = op(pct_pkg::K_MOVE, 2'h1, 5'h02); // see RULE13
      // Write working register
      8'b11111???: row = op(pct_pkg::K_MOVE, 2'h1, 5'h02); // see RULE14
      8'b10101???: row = op(pct_pkg::K_MOVE, 2'h2, 5'h03); // see RULE14
      8'b01111???: row = op(pct_pkg::K_MOVE, 2'h2, 5'h02); // see RULE14
      // Write direct byte
      8'hF5: row = op(pct_pkg::K_MOVE, 2'h2, 5'h02); // see RULE15
      8'b10001???: row = op(pct_pkg::K_MOVE, 2'h2, 5'h02); // see RULE15
      8'h85: row = op(pct_pkg::K_MOVE, 2'h3, 5'h03); // see RULE15
      8'h75: row = op(pct_pkg::K_MOVE, 2'h3, 5'h03); // see RULE15
      8'b1000011?: row = op(pct_pkg::K_MOVE, 2'h2, 5'h03); // see RULE15
      // Write indirect RAM, load data pointer
      8'b1111011?: row = op(pct_pkg::K_MOVE, 2'h1, 5'h02); // see RULE16
      8'b1010011?: row = op(pct_pkg::K_MOVE, 2'h2, 5'h03); // see RULE16
      8'b0111011?: row = op(pct_pkg::K_MOVE, 2'h2, 5'h02); // see RULE16
      8'h90: row = op(pct_pkg::K_MOVE, 2'h3, 5'h03); // see RULE16
      // Code table reads
      8'h93: row = op(pct_pkg::K_CODE, 2'h1, 5'h07); // see RULE17
      8'h83: row = op(pct_pkg::K_CODE, 2'h1, 5'h08); // see RULE17
      // External RAM
      8'b1110001?: row = op(pct_pkg::K_XRAM, 2'h1, 5'h05); // see RULE18
      8'hE0: row = op(pct_pkg::K_XRAM, 2'h1, 5'h06); // see RULE18
      8'b1111001?: row = op(pct_pkg::K_XRAM, 2'h1, 5'h04); // see RULE18
      8'hF0: row = op(pct_pkg::K_XRAM, 2'h1, 5'h05); // see RULE18
      // Stack and exchanges
      8'hC0: row = op(pct_pkg::K_STACK, 2'h2, 5'h05); // see RULE19
      8'hD0: row = op(pct_pkg::K_STACK, 2'h2, 5'h04); // see RULE19
      8'b11001???: row = op(pct_pkg::K_SWAP, 2'h1, 5'h03); // see RULE19
      8'hC5: row = op(pct_pkg::K_SWAP, 2'h2, 5'h04); // see RULE19
      8'b1100011?: row = op(pct_pkg::K_SWAP, 2'h1, 5'h04); // see RULE19
      8'b1101011?: row = op(pct_pkg::K_SWAP, 2'h1, 5'h04); // see RULE19
      // Calls and returns
      8'h12:
        row = op(pct_pkg::K_CALL, 2'h3, 5'h07); // see RULE20
      8'h22:
        row = op(pct_pkg::K_CALL, 2'h1, 5'h08); // see RULE20
      8'h32:
        row = op(pct_pkg::K_CALL, 2'h1, 5'h08); // see RULE20
      // Unconditional jumps
      8'h80:
        row = op(pct_pkg::K_JUMP, 2'h2, 5'h04); // see RULE21
      8'h02:
        row = op(pct_pkg::K_JUMP, 2'h3, 5'h05); // see RULE21
      8'h73:
        row = op(pct_pkg::K_JUMP, 2'h1, 5'h06); // see RULE21
      // Two-byte conditional branches
      8'h60:
        row = br(2'h2, 5'h03, 5'h05, pct_pkg::C_ZERO); // see RULE22
      8'h70:
        row = br(2'h2, 5'h03, 5'h05, pct_pkg::C_NZERO); // see RULE22
      8'b11011???:
        row = br(2'h2, 5'h03, 5'h05, pct_pkg::C_DNZ); // see RULE22
      8'h40:
        row = br(2'h2, 5'h02, 5'h04, pct_pkg::C_CARRY); // see RULE22
      8'h50:
        row = br(2'h2, 5'h02, 5'h04, pct_pkg::C_NCARRY); // see RULE22
      // Three-byte conditional branches
      8'h20:
        row = br(2'h3, 5'h04, 5'h06, pct_pkg::C_BSET); // see RULE23
      8'h10:
        row = br(2'h3, 5'h04, 5'h06, pct_pkg::C_BSET); // see RULE23
      8'h30:
        row = br(2'h3, 5'h04, 5'h06, pct_pkg::C_BCLR); // see RULE23
      8'hB4:
        row = br(2'h3, 5'h04, 5'h06, pct_pkg::C_UNEQ); // see RULE23
      8'hB5:
        row = br(2'h3, 5'h04, 5'h06, pct_pkg::C_UNEQ); // see RULE23
      8'b10111???:
        row = br(2'h3, 5'h04, 5'h06, pct_pkg::C_UNEQ); // see RULE23
      8'b1011011?:
        row = br(2'h3, 5'h04, 5'h06, pct_pkg::C_UNEQ); // see RULE23
      8'hD5:
        row = br(2'h3, 5'h04, 5'h06, pct_pkg::C_DNZ); // see RULE23
      // Carry and direct bit operations
      8'hC3:
        row = op(pct_pkg::K_BIT, 2'h1, 5'h01); // see RULE24
      8'hD3:
        row = op(pct_pkg::K_BIT, 2'h1, 5'h01); // see RULE24
      8'hB3:
        row = op(pct_pkg::K_BIT, 2'h1, 5'h01); // see RULE24
      8'hC2:
        row = op(pct_pkg::K_BIT, 2'h2, 5'h03); // see RULE24
      8'hD2:
        row = op(pct_pkg::K_BIT, 2'h2, 5'h03); // see RULE24
      8'hB2:
        row = op(pct_pkg::K_BIT, 2'h2, 5'h03); // see RULE24
      8'h92:
        row = op(pct_pkg::K_BIT, 2'h2, 5'h03); // see RULE24
      8'h82:
        row = op(pct_pkg::K_BIT, 2'h2, 5'h02); // see RULE24
      8'hB0:
        row = op(pct_pkg::K_BIT, 2'h2, 5'h02); // see RULE24
      8'h72:
        row = op(pct_pkg::K_BIT, 2'h2, 5'h02); // see RULE24
      8'hA0:
        row = op(pct_pkg::K_BIT, 2'h2, 5'h02); // see RULE24
      8'hA2:
        row = op(pct_pkg::K_BIT, 2'h2, 5'h02); // see RULE24
      // Unassigned code: retire in one cycle so the core never hangs
      default: row = op(pct_pkg::K_ILLEGAL, 2'h1, 5'h01);
    endcase
  end

  always_comb begin
    case (row.cond)
      pct_pkg::C_ZERO: take = flags_in.acc_zero;
      pct_pkg::C_NZERO: take = ~flags_in.acc_zero;
      pct_pkg::C_CARRY: take = flags_in.carry;
      pct_pkg::C_NCARRY: take = ~flags_in.carry;
      pct_pkg::C_BSET: take = flags_in.bit_set;
      pct_pkg::C_BCLR: take = ~flags_in.bit_set;
      pct_pkg::C_UNEQ: take = flags_in.unequal;
      pct_pkg::C_DNZ: take = flags_in.dec_nonzero;
      default: take = 1'b0;
    endcase
    dec.kind = row.kind;
    dec.len = row.len;
    dec.cycles = take ? row.cyc_tk : row.cyc_nt; // see RULE25
    dec.taken = take;
  end

  assign accept = op_valid_in && (state_reg == pct_pkg::ST_IDLE);

  always_comb begin
    case (state_reg)
      pct_pkg::ST_IDLE: state_next = accept ? pct_pkg::ST_EXEC : pct_pkg::ST_IDLE;
      pct_pkg::ST_EXEC: state_next = (cnt_reg == 5'h00) ? pct_pkg::ST_IDLE : pct_pkg::ST_EXEC;
      default: state_next = pct_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_reg <= pct_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // One count per core clock; busy stands exactly the table figure
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cnt_reg <= pct_pkg::CNT_RESET;
    end else if (accept) begin
      cnt_reg <= dec.cycles - 5'h01; // see RULE25
    end else if (cnt_reg != 5'h00) begin
      cnt_reg <= cnt_reg - 5'h01;
    end
  end

  // Flags are sampled once at issue; later changes cannot alter timing
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      result_reg <= pct_pkg::RESULT_RESET;
    end else if (accept) begin
      result_reg <= dec;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (state_reg == pct_pkg::ST_EXEC) && (cnt_reg == 5'h00);
    end
  end

  assign ready_out = state_reg[0];
  assign busy_out = state_reg[1];
  assign done_out = done_reg;
  assign result_out = result_reg;

endmodule // pct_decoder

/* pct_decoder_properties.sv */
// Concurrent checks on the opcode timing decoder ports
`timescale 1ns/1ps

module pct_decoder_properties (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic op_valid_in,
  input wire logic [7:0] opcode_in,
  input wire logic wide_form_in,
  input wire pct_pkg::pct_flags_t flags_in,
  input wire logic ready_out,
  input wire logic busy_out,
  input wire logic done_out,
  input wire pct_pkg::pct_result_t result_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  logic issue;
  logic [5:0] busy_cnt_reg;
  assign issue = op_valid_in && ready_out;
  // Length of the current busy run, held through the done cycle
  always_ff @(posedge mclk_in) begin
    if (rst_in || !busy_out) begin
      busy_cnt_reg <= 6'h00;
    end else begin
      busy_cnt_reg <= busy_cnt_reg + 6'h01;
    end
  end
  a_issue_starts_busy: assert property (issue |=> busy_out && !ready_out)
    else $error("accepted opcode did not start execution");
  a_busy_count_match: assert property (done_out |-> busy_cnt_reg == {1'b0, result_out.cycles})
    else $error("busy length differs from reported cycles");
  a_done_single_pulse: assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
  a_done_follows_busy: assert property ($fell(busy_out) |-> done_out && ready_out)
    else $error("done missing after busy");
  a_ready_busy_excl: assert property (busy_out |-> !ready_out)
    else $error("ready while busy");
  a_result_holds: assert property (busy_out && $past(busy_out) |-> $stable(result_out))
    else $error("result changed during execution");
  a_taken_only_branch: assert property (busy_out && result_out.taken |-> result_out.kind == pct_pkg::K_BRANCH)
    else $error("taken set on non-branch");
  a_zero_branch_time: assert property (issue && opcode_in == 8'h60 |=>
    result_out.cycles == ($past(flags_in.acc_zero) ? 5'h05 : 5'h03))
    else $error("zero branch cycle count wrong");
  a_product_time: assert property (issue && opcode_in == 8'hA4 |=>
    result_out.cycles == ($past(wide_form_in) ? 5'h14 : 5'h0B))
    else $error("multiply cycle count wrong");
  a_nop_one_cycle: assert property (issue && opcode_in == 8'h00 |=> busy_out ##1 done_out)
    else $error("no-operation not one cycle");
endmodule // pct_decoder_properties

bind pct_decoder pct_decoder_properties u_props (.mclk_in(mclk_in), .rst_in(rst_in),
  .op_valid_in(op_valid_in), .opcode_in(opcode_in), .wide_form_in(wide_form_in),
  .flags_in(flags_in), .ready_out(ready_out), .busy_out(busy_out), .done_out(done_out),
  .result_out(result_out));

/* pct_core_model.sv */
// Core-side model that offers opcodes and holds them until accepted
`timescale 1ns/1ps

module pct_core_model (
  input wire logic mclk_in,
  input wire logic ready_in,
  output logic op_valid_out,
  output logic [7:0] opcode_out,
  output logic wide_form_out,
  output pct_pkg::pct_flags_t flags_out
);
  initial begin
    op_valid_out = 1'b0;
    opcode_out = 8'h00;
    wide_form_out = 1'b0;
    flags_out = '0;
  end
  // Held until ready is seen at an edge; refused offers simply retry
  task automatic issue(input logic [7:0] op, input logic w, input pct_pkg::pct_flags_t f);
    op_valid_out <= 1'b1;
    opcode_out <= op;
    wide_form_out <= w;
    flags_out <= f;
    do @(posedge mclk_in); while (ready_in !== 1'b1);
  endtask
  task automatic idle();
    op_valid_out <= 1'b0;
  endtask
endmodule // pct_core_model

/* tb_top.sv */
// Self-checking bench for the opcode timing decoder
`timescale 1ns/1ps

module tb_top;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic op_valid, wide, ready, busy, done;
  logic [7:0] opcode;
  pct_pkg::pct_flags_t flags;
  pct_pkg::pct_result_t result, e;
  pct_pkg::pct_result_t exp_q[$];
  int error_cnt = 0;
  int comparisons = 0;
  int bcnt = 0;
  logic [16:0] rnd = 17'h17D7A;
  // Row: opcode, kind, length, not-taken, taken, mode (1 flag, 2 not flag, 3 wide form)
  logic [35:0] tbl [] = '{
    36'h280101010, 36'h2F0101010, 36'h250202020, 36'h260102020, 36'h240202020,
    36'h3F0101010, 36'h350202020, 36'h370102020, 36'h340202020,
    36'h950202020, 36'h940202020, 36'h960102020, 36'h980101010, 36'h9F0101010,
    36'h040101010, 36'h0F0102020, 36'h050203030, 36'h070103030, 36'hA30104040,
    36'h140101010, 36'h180102020, 36'h150203030, 36'h160103030,
    36'hA4010B143, 36'h84010B143, 36'hD40101010,
    36'h5F1101010, 36'h561102020, 36'h521203030, 36'h531303030,
    36'h481101010, 36'h441202020, 36'h421203030, 36'h431303030,
    36'h6F1101010, 36'h651202020, 36'h621203030, 36'h631303030,
    36'hE41101010, 36'hF41101010, 36'h231101010, 36'h331101010, 36'h031101010,
    36'h131101010, 36'h001101010, 36'hC41104040,
    36'hE82101010, 36'hE52202020, 36'hE72102020, 36'h742202020,
    36'hF82102020, 36'hAF2203030, 36'h782202020, 36'hF52202020, 36'h882202020,
    36'h852303030, 36'h862203030, 36'h752303030, 36'hF62102020, 36'hA72203030,
    36'h762202020, 36'h902303030, 36'h934107070, 36'h834108080,
    36'hE23105050, 36'hE03106060, 36'hF33104040, 36'hF03105050,
    36'hC05205050, 36'hD05204040, 36'hC86103030, 36'hC56204040, 36'hC66104040,
    36'hD76104040, 36'h117207070, 36'hF17207070, 36'h127307070, 36'h227108080,
    36'h327108080, 36'h018204040, 36'hE18204040, 36'h808204040, 36'h028305050,
    36'h738106060, 36'h609203051, 36'h709203052, 36'hDF9203051, 36'h409202041,
    36'h509202042, 36'h209304061, 36'h309304062, 36'h109304061, 36'hB59304061,
    36'hB49304061, 36'hBB9304061, 36'hB79304061, 36'hD59304061, 36'hC3A101010,
    36'hD3A101010, 36'hB3A101010, 36'hC2A203030, 36'hD2A203030, 36'hB2A203030,
    36'h82A202020, 36'hB0A202020, 36'h72A202020, 36'hA0A202020, 36'hA2A202020,
    36'h92A203030, 36'hA5B101010};

  always #10 mclk_in = ~mclk_in;

  pct_core_model u_core (.mclk_in(mclk_in), .ready_in(ready), .op_valid_out(op_valid),
    .opcode_out(opcode), .wide_form_out(wide), .flags_out(flags));
  pct_decoder u_dut (.mclk_in(mclk_in), .rst_in(rst_in), .op_valid_in(op_valid),
    .opcode_in(opcode), .wide_form_in(wide), .flags_in(flags), .ready_out(ready),
    .busy_out(busy), .done_out(done), .result_out(result));

  function automatic logic [16:0] lfsr_next(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction

  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task give_verdict;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Flags all follow one random bit, drawn afresh for each row on each of the three passes; only branch rows can be taken
  task automatic run(input logic [35:0] t);
    logic f;
    logic w;
    pct_pkg::pct_result_t x;
    rnd = lfsr_next(rnd);
    f = rnd[0];
    w = rnd[5];
    x.kind = pct_pkg::pct_kind_t'(t[27:24]);
    x.len = t[21:20];
    x.taken = (t[3:0] == 4'h1) ? f : ((t[3:0] == 4'h2) ? !f : 1'b0);
    x.cycles = ((t[3:0] == 4'h3) ? w : x.taken) ? t[8:4] : t[16:12];
    exp_q.push_back(x);
    u_core.issue(t[35:28], w, pct_pkg::pct_flags_t'({5{f}}));
  endtask

  // Result checker: two checks per completed instruction
  always @(posedge mclk_in) begin
    if (busy === 1'b1) bcnt++;
    if (done === 1'b1) begin
      if (exp_q.size() == 0) chk(1'b0, "done without issue");
      else begin
        e = exp_q.pop_front();
        chk(result === e, "result mismatch");
        chk(bcnt == int'(e.cycles), "busy length mismatch");
      end
      bcnt = 0;
    end
  end

  initial begin
    repeat (8) @(posedge mclk_in);
    rst_in <= 1'b0;
    #1;
    chk(result === pct_pkg::RESULT_RESET && ready === 1'b1, "reset outputs");
    chk(busy === 1'b0 && done === 1'b0, "reset flags");
    @(posedge mclk_in);
    for (int p = 0; p < 3; p++) foreach (tbl[i]) run(tbl[i]);
    u_core.idle();
    for (int w = 0; w < 40 && exp_q.size() > 0; w++) @(posedge mclk_in);
    chk(exp_q.size() == 0, "missing done");
    give_verdict();
  end

  // Worst case is far below this span
  initial begin
    #300000;
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end
endmodule // tb_top
